/* core/sps_consts.svh */
// Constants of the stepper phase sequencer: states and protection codes.
// Assumes inclusion by its bare name from the package and design files.
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
`define SPS_STATE_W      3
`define SPS_STATE_RESET  3'h0
`define SPS_TEMP_W       8
`define SPS_TEMP_TRIP    8'ha5
`define SPS_TEMP_HYST    8'h0f
`define SPS_INT_W        3
`define SPS_INT_STEP     0
`define SPS_INT_OCD      1
`define SPS_INT_THERM    2
`define SPS_ADDR_W       2
`define SPS_ADDR_STATUS  2'h0
`define SPS_ADDR_MASK    2'h1
`define SPS_ADDR_STATE   2'h2
`define SPS_ADDR_TEMP    2'h3
`endif

/* core/sps_pkg.sv */
// Types of the stepper phase sequencer.
// Assumes sps_consts.svh is available on the include path.
`include "sps_consts.svh"
package sps_pkg;
  // Bridge command for both windings
  typedef struct packed {
    logic en_a;   // Bridge A enable
    logic ph_a;   // Bridge A polarity
    logic en_b;   // Bridge B enable
    logic ph_b;   // Bridge B polarity
  } sps_bridge_t;
endpackage

/* core/sps_stepper_phase_sequencer.sv */
// Phase sequencer with overcurrent and thermal shutdown, register port.
// Assumes pins from the motion controller are asynchronous to clk and
// an external RC on the enable pin; pin level sampled via sync.
//
// Design decisions made here: the strobed register port and the register addresses.
`include "sps_consts.svh"
module sps_stepper_phase_sequencer (
  input  wire logic                     clk,          // 100 MHz clock
  input  wire logic                     nrst,         // Async reset, low
  input  wire logic                     step_clk,     // Step pin
  input  wire logic                     rotation_direction, // 1 forward
  input  wire logic                     half_full,    // 1 half step
  input  wire logic                     seq_rst_n,    // Sequencer reset pin
  input  wire logic [1:0]               overcurrent_detector, // Per bridge
  input  wire logic [`SPS_TEMP_W-1:0]   junction_temp,// Sensor code, degC
  input  wire logic                     en_pin_in,    // Enable pin level
  output logic                          en_pin_out,   // Enable pin drive
  output logic                          en_pin_oe,    // Pull-down active
  output sps_pkg::sps_bridge_t          bridge,       // Bridge commands
  input  wire logic [`SPS_ADDR_W-1:0]   addr,         // Register address
  input  wire logic [7:0]               wdata,        // Write data
  input  wire logic                     wr,           // Write strobe
  input  wire logic                     rd,           // Read strobe
  output logic [7:0]                    rdata,        // Read data
  output logic                          irq           // Level interrupt
);

  // Synchroniser chains for all pins; stage 0 read only by stage 1
  logic [6:0] sync0_reg;      // First stage
  logic [6:0] sync1_reg;      // Second stage
  logic [6:0] sync_in;        // Raw pin vector
  logic       step_d_reg;     // Step level delayed for edge detect
  logic [`SPS_TEMP_W-1:0] temp0_reg; // Temp first stage
  logic [`SPS_TEMP_W-1:0] temp1_reg; // Temp second stage
  logic [`SPS_TEMP_W-1:0] temp2_reg; // Temp third stage, for compare
  logic [`SPS_TEMP_W-1:0] temp_s_reg;  // Accepted temperature code
  logic [`SPS_TEMP_W-1:0] temp_s_next; // Next accepted code

  assign sync_in = {en_pin_in, overcurrent_detector, seq_rst_n,
                    half_full, rotation_direction, step_clk};

  // Two-flop synchronisers; temp word also passes a stability filter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync0_reg  <= 7'h00;
      sync1_reg  <= 7'h00;
      step_d_reg <= 1'b0;
      temp0_reg  <= 8'h00;
      temp1_reg  <= 8'h00;
      temp2_reg  <= 8'h00;
      temp_s_reg <= 8'h00;
    end else begin
      sync0_reg  <= sync_in;
      sync1_reg  <= sync0_reg;
      step_d_reg <= sync1_reg[0];
      temp0_reg  <= junction_temp;
      temp1_reg  <= temp0_reg;
      temp2_reg  <= temp1_reg;
      temp_s_reg <= temp_s_next;
    end
  end

  // Bits of the temp word may land in different cycles; accept a word
  // only once it has stood unchanged for two samples
  always_comb begin
    temp_s_next = temp_s_reg;
    if (temp1_reg == temp2_reg) begin
      temp_s_next = temp1_reg;
    end
  end

  logic s_dir;      // Synced direction
  logic s_half;     // Synced half/full select
  logic s_rst_n;    // Synced sequencer reset
  logic s_ocd;      // Any bridge over current
  logic s_en_pin;   // Synced enable pin level
  logic step_rise;  // One-cycle step edge
  assign s_dir     = sync1_reg[1];
  assign s_half    = sync1_reg[2];
  assign s_rst_n   = sync1_reg[3];
  assign s_ocd     = |sync1_reg[5:4];
  assign s_en_pin  = sync1_reg[6];
  assign step_rise = sync1_reg[0] & ~step_d_reg;

  // Index 0..7 stands for documented state 1..8
  logic [`SPS_STATE_W-1:0] state_reg;   // Current state index
  logic [`SPS_STATE_W-1:0] state_next;  // Next state index
  logic                    therm_reg;   // Thermal shutdown latched
  logic                    therm_next;  // Next thermal flag
  logic                    en_out_reg;  // Pull-down request
  logic                    en_out_next; // Next pull-down request

  // Step size 1 in half step; 2 in full step keeps parity, so odd
  // states stay normal drive and even states stay wave drive
  function automatic logic [`SPS_STATE_W-1:0] step_to(
    input logic [`SPS_STATE_W-1:0] cur,
    input logic                    fwd,
    input logic                    half);
    logic [`SPS_STATE_W-1:0] inc;
    inc = half ? 3'h1 : 3'h2;
    step_to = fwd ? cur + inc : cur - inc; // Wraps modulo eight
  endfunction

  // Sequencer, thermal hysteresis and overcurrent pull-down
  always_comb begin
    state_next  = state_reg;
    therm_next  = therm_reg;
    en_out_next = s_ocd;
    if (!s_rst_n) begin
      state_next = `SPS_STATE_RESET;
    end else if (step_rise) begin
      state_next = step_to(state_reg, s_dir, s_half);
    end
    if (temp_s_reg >= `SPS_TEMP_TRIP) begin
      therm_next = 1'b1;
    end else if (temp_s_reg <= `SPS_TEMP_TRIP - `SPS_TEMP_HYST) begin
      therm_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= `SPS_STATE_RESET;
      therm_reg  <= 1'b0;
      en_out_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      therm_reg  <= therm_next;
      en_out_reg <= en_out_next;
    end
  end

  // Open drain: drive low only while overcurrent is present
  assign en_pin_out = 1'b0;
  assign en_pin_oe  = en_out_reg;

  // Phase table by index; odd documented states have both phases on
  function automatic sps_pkg::sps_bridge_t phase_of(
    input logic [`SPS_STATE_W-1:0] s);
    sps_pkg::sps_bridge_t b;
    b = '{en_a: 1'b1, ph_a: 1'b1, en_b: 1'b1, ph_b: 1'b1};
    case (s)
      3'h0: b = '{en_a: 1'b1, ph_a: 1'b1, en_b: 1'b1, ph_b: 1'b1};
      3'h1: b = '{en_a: 1'b0, ph_a: 1'b1, en_b: 1'b1, ph_b: 1'b1};
      3'h2: b = '{en_a: 1'b1, ph_a: 1'b0, en_b: 1'b1, ph_b: 1'b1};
      3'h3: b = '{en_a: 1'b1, ph_a: 1'b0, en_b: 1'b0, ph_b: 1'b1};
      3'h4: b = '{en_a: 1'b1, ph_a: 1'b0, en_b: 1'b1, ph_b: 1'b0};
      3'h5: b = '{en_a: 1'b0, ph_a: 1'b0, en_b: 1'b1, ph_b: 1'b0};
      3'h6: b = '{en_a: 1'b1, ph_a: 1'b1, en_b: 1'b1, ph_b: 1'b0};
      default: b = '{en_a: 1'b1, ph_a: 1'b1, en_b: 1'b0, ph_b: 1'b0};
    endcase
    phase_of = b;
  endfunction

  // Bridge command registered; any protection or low pin forces off
  sps_pkg::sps_bridge_t bridge_reg;   // Output register
  sps_pkg::sps_bridge_t bridge_next;  // Next command
  logic                 off;          // Forced-off condition
  always_comb begin
    off         = therm_reg | en_out_reg | ~s_en_pin;
    bridge_next = phase_of(state_reg);
    if (off) begin
      bridge_next.en_a = 1'b0;
      bridge_next.en_b = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) bridge_reg <= '0;
    else       bridge_reg <= bridge_next;
  end
  assign bridge = bridge_reg;

  // Register port: sticky status, mask, state and temperature readback
  logic [`SPS_INT_W-1:0] stat_reg;   // Sticky events
  logic [`SPS_INT_W-1:0] stat_next;
  logic [`SPS_INT_W-1:0] mask_reg;   // Interrupt mask
  logic [`SPS_INT_W-1:0] mask_next;
  logic [7:0]            rdata_reg;  // Read data
  logic [7:0]            rdata_next;
  logic                  irq_reg;    // Interrupt output
  logic                  irq_next;
  logic [`SPS_INT_W-1:0] ev;         // Events this cycle

  always_comb begin
    ev = '0;
    ev[`SPS_INT_STEP]  = step_rise & s_rst_n;
    ev[`SPS_INT_OCD]   = en_out_next & ~en_out_reg;
    ev[`SPS_INT_THERM] = therm_next & ~therm_reg;
    stat_next  = stat_reg;
    mask_next  = mask_reg;
    rdata_next = 8'h00;
    if (rd) begin
      if (addr == `SPS_ADDR_STATUS) begin
        rdata_next = {5'h00, stat_reg};
        stat_next  = '0;                 // Read clears
      end else if (addr == `SPS_ADDR_MASK) begin
        rdata_next = {5'h00, mask_reg};
      end else if (addr == `SPS_ADDR_STATE) begin
        rdata_next = {3'h0, therm_reg, en_out_reg, state_reg};
      end else begin
        rdata_next = temp_s_reg;
      end
    end
    if (wr && addr == `SPS_ADDR_MASK) begin
      mask_next = wdata[`SPS_INT_W-1:0];
    end
    stat_next = stat_next | ev;          // Set wins over clear
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_reg  <= '0;
      mask_reg  <= '0;
      rdata_reg <= 8'h00;
      irq_reg   <= 1'b0;
    end else begin
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
    end
  end
  assign rdata = rdata_reg;
  assign irq   = irq_reg;

endmodule

/* testbench/sps_motion_ctrl.sv */
// Motion controller model: step, direction and mode pins.
// Assumes one step request at a time from the bench.
module sps_motion_ctrl (
  input wire logic clk,                // Clock
  input wire logic req,                // Step request
  input wire logic dir_req,            // Wanted direction
  input wire logic half_req,           // Wanted mode
  output logic     step_clk,           // Step pin
  output logic     rotation_direction, // Direction pin
  output logic     half_full           // Mode pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg = 4'h0; // Cycles left in pulse
  initial begin
    rotation_direction = 1'b1;
    half_full = 1'b1;
  end
  // Pins move only between pulses, never near a step edge
  always @(posedge clk) begin
    if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else if (req) begin
      cnt_reg <= 4'hc;
    end else begin
      rotation_direction <= dir_req;
      half_full <= half_req;
    end
  end
  // Six cycles high then six low: one rising edge
  assign step_clk = cnt_reg > 4'h6;
endmodule

/* testbench/sps_stepper_phase_sequencer_assertions.sv */
// Port checker of the phase sequencer.
// Assumes it is bound to the top module below.
`include "sps_consts.svh"
module sps_chk (
  input wire logic                 clk,        // Clock
  input wire logic                 nrst,       // Reset
  input wire logic                 step_clk,   // Step pin
  input wire logic                 seq_rst_n,  // Seq reset
  input wire logic [1:0]           overcurrent_detector, // Faults
  input wire logic [7:0]           junction_temp, // Temp
  input wire logic                 en_pin_out, // Pin drive
  input wire logic                 en_pin_oe,  // Pull-down
  input wire sps_pkg::sps_bridge_t bridge,     // Bridges
  input wire logic [1:0]           addr,       // Address
  input wire logic [7:0]           wdata,      // Data
  input wire logic                 wr,         // Write
  input wire logic                 irq         // Interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_pin_open: assert property (!en_pin_out)
    else $error("pin high");
  a_oc_pull: assert property (
    (|overcurrent_detector)[*5] |-> en_pin_oe) else $error("no pull-down");
  a_oc_free: assert property (
    (overcurrent_detector == 2'h0)[*5] |-> !en_pin_oe)
    else $error("pull-down stuck");
  a_oc_off: assert property (
    en_pin_oe |=> !bridge.en_a && !bridge.en_b)
    else $error("bridge on in fault");
  // Sync, stability filter, flag and bridge register: seven samples
  a_hot_off: assert property (
    (junction_temp >= `SPS_TEMP_TRIP)[*7] |-> !bridge.en_a && !bridge.en_b)
    else $error("bridge on hot");
  a_step_move: assert property (
    $rose(step_clk) && !en_pin_oe && junction_temp < 8'h96
    |-> ##[2:6] $changed(bridge)) else $error("no step");
  a_seq_home: assert property (
    (!seq_rst_n && junction_temp < 8'h96)[*8] |-> bridge == 4'hf)
    else $error("not home");
  a_irq_mask: assert property (
    wr && addr == `SPS_ADDR_MASK && wdata == 8'h00 |-> ##2 !irq)
    else $error("irq masked");
endmodule
bind sps_stepper_phase_sequencer sps_chk u_sps_chk (.clk, .nrst, .step_clk,
  .seq_rst_n, .overcurrent_detector, .junction_temp, .en_pin_out, .en_pin_oe,
  .bridge, .addr, .wdata, .wr, .irq);

/* testbench/sps_stepper_phase_sequencer_tb.sv */
// Bench of the phase sequencer: modes, protection, registers.
// Assumes the controller model and checker are compiled first.
`include "sps_consts.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %0t %h %h", $time, (a), (e)); end end
module sps_stepper_phase_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk, nrst, req, dir_req, half_req, seq_rst_n, wr, rd;
  logic                 step_clk, rotation_direction, half_full;
  logic                 en_pin_out, en_pin_oe, irq;
  logic [1:0]           overcurrent_detector, addr;
  logic [7:0]           junction_temp, wdata, rdata, rv;
  logic [2:0]           s;     // Expected state index
  sps_pkg::sps_bridge_t bridge;
  int                   checks, miscompares, cyc;
  // Temperature steps with expected shutdown in bit 8
  logic [8:0]           tt [4] = '{9'h1a5, 9'h197, 9'h096, 9'h0a4};
  // Bridge command {en_a, ph_a, en_b, ph_b} by state index
  logic [3:0]           pt [8] = '{4'hf, 4'h7, 4'hb, 4'h9,
                                   4'ha, 4'h2, 4'he, 4'hc};
  sps_motion_ctrl u_sps_motion_ctrl (.clk, .req, .dir_req, .half_req,
    .step_clk, .rotation_direction, .half_full);
  // Open-drain enable pin; the RC restores it at once
  sps_stepper_phase_sequencer u_sps_stepper_phase_sequencer (.clk, .nrst,
    .step_clk, .rotation_direction, .half_full, .seq_rst_n,
    .overcurrent_detector, .junction_temp, .en_pin_in(en_pin_oe ? en_pin_out
    : 1'b1), .en_pin_out, .en_pin_oe, .bridge, .addr, .wdata, .wr, .rd,
    .rdata, .irq);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Run is about 1570 cycles; ceiling well above
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task xfer(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task stp(input logic d, input logic h);
    @(posedge clk);
    dir_req <= d;
    half_req <= h;
    repeat (4) @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task run(input logic h, input logic d, input logic p);
    @(posedge clk);
    seq_rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    seq_rst_n <= 1'b1;
    s = 3'h0;
    xfer(1'b0, `SPS_ADDR_STATE, 8'h00);
    `CHK(rv[2:0], s)
    if (p) begin
      stp(d, 1'b1);
      s = d ? 3'h1 : 3'h7;
      xfer(1'b0, `SPS_ADDR_STATE, 8'h00);
      `CHK(rv[2:0], s)
    end
    for (int i = 0; i < 8; i++) begin
      stp(d, h);
      s = d ? s + (h ? 3'h1 : 3'h2) : s - (h ? 3'h1 : 3'h2);
      xfer(1'b0, `SPS_ADDR_STATE, 8'h00);
      `CHK(rv[2:0], s)
      `CHK(bridge.en_a & bridge.en_b, !s[0])
      `CHK(bridge, pt[s])
    end
  endtask
  initial begin
    nrst = 1'b0;
    req = 1'b0;
    dir_req = 1'b1;
    half_req = 1'b1;
    seq_rst_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    overcurrent_detector = 2'h0;
    junction_temp = 8'h19;
    addr = 2'h0;
    wdata = 8'h00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(bridge, 4'hf)
    // Half up/down, normal up/down, wave up/down
    for (int m = 0; m < 6; m++) run(m < 2, !m[0], m > 3);
    xfer(1'b0, `SPS_ADDR_STATUS, 8'h00);
    xfer(1'b1, `SPS_ADDR_MASK, 8'h06);
    xfer(1'b1, `SPS_ADDR_STATUS, 8'hff);
    for (int b = 1; b < 3; b++) begin
      @(posedge clk);
      overcurrent_detector <= b[1:0];
      repeat (6) @(posedge clk);
      `CHK({en_pin_oe, bridge.en_a, bridge.en_b, irq}, 4'h9)
      xfer(1'b0, `SPS_ADDR_STATUS, 8'h00);
      `CHK(rv, 8'h02)
      @(posedge clk);
      overcurrent_detector <= 2'h0;
      repeat (6) @(posedge clk);
      `CHK({en_pin_oe, irq}, 2'h0)
    end
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      junction_temp <= tt[t][7:0];
      repeat (6) @(posedge clk);
      xfer(1'b0, `SPS_ADDR_STATE, 8'h00);
      `CHK(rv[4], tt[t][8])
      `CHK(bridge.en_a | bridge.en_b, !tt[t][8])
    end
    `CHK(irq, 1'b1)
    xfer(1'b1, `SPS_ADDR_MASK, 8'h00);
    xfer(1'b0, `SPS_ADDR_STATUS, 8'h00);
    `CHK({rv, irq}, 9'h008)
    complete_run;
  end
endmodule
